// *** ite_map.svh ***
// Encodings, limits and bus addresses for the instruction tail execute slice
`ifndef ITE_MAP_SVH
`define ITE_MAP_SVH
`define ITE_OP_POOL_INT 6'h00
`define ITE_OP_POOL_FLT 6'h15
`define ITE_OP_XOR_IMM 6'h1C
`define ITE_MINOR_INT_EXT 6'h3C
`define ITE_MINOR_FLT_EXT 6'h3B
`define ITE_SEC_WAIT 10'h24D
`define ITE_SEC_WRPREV 10'h3C5
`define ITE_SEC_BSWAP 10'h1EC
`define ITE_FUNC_XOR 10'h310
`define ITE_FSEC_TRW 8'hAC
`define ITE_FSEC_TRL 8'h8C
`define ITE_RMODE_TRUNC 2'h1
`define ITE_W_MAX 32'h7FFFFFFF
`define ITE_L_MAX 64'h7FFFFFFFFFFFFFFF
`define ITE_ADDR_OFF 32'h00000000
`define ITE_ADDR_CTRL 32'h00000004
`define ITE_ADDR_STAT 32'h00000008
`define ITE_CTRL_RESET 32'h00000000
`endif

// *** ite_pkg.sv ***
// Types shared by the instruction tail execute slice
package ite_pkg;
  typedef enum logic [3:0] {
    ITE_OP_NONE, ITE_OP_TRW, ITE_OP_TRL, ITE_OP_WAIT, ITE_OP_WRPREV,
    ITE_OP_BSWAP, ITE_OP_XOR, ITE_OP_XOR_IMM, ITE_OP_RESERVED
  } ite_op_t;
  typedef struct packed {
    logic we;
    logic [4:0] idx;
    logic [31:0] data;
  } ite_gpr_wr_t;
  typedef struct packed {
    logic we;
    logic [4:0] idx;
    logic [63:0] data;
  } ite_fpr_wr_t;
  typedef struct packed {
    logic unimpl;
    logic invalid;
    logic inexact;
  } ite_fcause_t;
endpackage

// *** ite_slice.sv ***
// Decode and execute slice for truncation, standby wait, shadow write, byte swap and xor
`timescale 1ns/100ps
`include "ite_map.svh"
module ite_slice
  import ite_pkg::*;
#(
  parameter int SHADOW_SETS = 4
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Instruction issue
  input wire logic issue_valid,
  input wire logic [31:0] issue_instr,
  input wire logic [31:0] issue_pc,
  input wire logic [31:0] rs_value,
  input wire logic [31:0] rt_value,
  input wire logic [63:0] fs_value,
  // Control state from the pipeline
  input wire logic cp0_usable,
  input wire logic release2,
  input wire logic fpu64,
  input wire logic fp_register_width_mode,
  input wire logic [1:0] previous_shadow_set_field,
  input wire logic fp_invalid_enable,
  // Wake sources, asynchronous to the core
  input wire logic irq_enabled_pin,
  input wire logic irq_masked_pin,
  input wire logic ext_req_pin,
  input wire logic nmi_pin,
  input wire logic soft_reset_pin,
  // Results
  output ite_gpr_wr_t gpr_wr,
  output ite_gpr_wr_t shadow_wr,
  output logic [1:0] shadow_set,
  output ite_fpr_wr_t fpr_wr,
  output ite_fcause_t fp_cause,
  output logic fp_invalid_flag_set,
  output logic [1:0] fp_round_mode,
  // Exceptions and pipeline control
  output logic exc_cop_unusable,
  output logic exc_reserved,
  output logic exc_fp_invalid,
  output logic exc_interrupt,
  output logic exc_nmi,
  output logic exc_reset,
  output logic [31:0] exception_return_pc,
  output logic pipe_stall,
  output logic standby
);

  typedef enum logic [1:0] {ITE_RUN, ITE_STANDBY} ite_state_t;

  // Float to integer truncation, width selects word or long
  typedef struct packed {
    logic [63:0] value;
    logic invalid;
    logic inexact;
    logic unimpl;
  } ite_cvt_t;

  function automatic ite_cvt_t trunc_fp(input logic [63:0] src, input logic dbl, input logic is_long);
    ite_cvt_t r;
    logic sign;
    logic [10:0] e;
    logic [52:0] mant;
    logic signed [12:0] ue;
    logic [127:0] sh;
    logic [63:0] mag;
    logic [63:0] lim;
    logic nan_inf;
    logic frac_lost;
    r = '0;
    if (dbl) begin
      sign = src[63];
      e = src[62:52];
      mant = {(e != 11'h000), src[51:0]};
      nan_inf = (e == 11'h7FF);
      ue = $signed({2'b00, e}) - 13'sd1075;
    end else begin
      sign = src[31];
      e = {3'h0, src[30:23]};
      mant = {29'h0, (e != 11'h000), src[22:0]};
      nan_inf = (src[30:23] == 8'hFF);
      ue = $signed({2'b00, e}) - 13'sd150;
    end
    // Subnormal source is left to software
    r.unimpl = (e == 11'h000) && (mant != 53'h0);
    sh = {75'h0, mant};
    frac_lost = 1'b0;
    mag = 64'h0;
    lim = is_long ? 64'h8000000000000000 : 64'h0000000080000000;
    if (ue >= 13'sd0) begin
      if (ue > 13'sd63) begin
        nan_inf = nan_inf | (mant != 53'h0);
      end else begin
        sh = sh << ue[5:0];
        if (sh[127:64] != 64'h0) begin
          nan_inf = 1'b1;
        end
        mag = sh[63:0];
      end
    end else if (ue > -13'sd64) begin
      mag = sh[63:0] >> (-ue);
      frac_lost = ((mag << (-ue)) != sh[63:0]);
    end else begin
      frac_lost = (mant != 53'h0);
    end
    r.invalid = nan_inf || (sign ? (mag > lim) : (mag >= lim));
    r.inexact = frac_lost && !r.invalid;
    if (r.invalid) begin
      r.value = is_long ? `ITE_L_MAX : {32'h0, `ITE_W_MAX};
    end else begin
      r.value = sign ? (64'h0 - mag) : mag;
      if (!is_long) begin
        r.value = {32'h0, r.value[31:0]};
      end
    end
    return r;
  endfunction

  // Bus registers: last issued pc, control, status
  logic [31:0] ctrl_r;
  logic ph_valid_r;
  logic ph_write_r;
  logic [31:0] ph_addr_r;
  logic bus_take;
  assign bus_take = hsel && hready && htrans[1];
  // Zero wait states, response always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid_r <= 1'b0;
      ph_write_r <= 1'b0;
      ph_addr_r <= 32'h0;
    end else if (hready) begin
      ph_valid_r <= bus_take;
      ph_write_r <= hwrite;
      ph_addr_r <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `ITE_CTRL_RESET;
    end else if (ph_valid_r && ph_write_r && ph_addr_r == `ITE_ADDR_CTRL) begin
      ctrl_r <= hwdata;
    end
  end

  // ctrl_r[0]: masked interrupts also wake standby
  logic masked_wake_en;
  assign masked_wake_en = ctrl_r[0];

  // Wake pin synchronisers
  logic [4:0] wake_s1_r;
  logic [4:0] wake_s2_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_s1_r <= 5'h0;
      wake_s2_r <= 5'h0;
    end else begin
      wake_s1_r <= {soft_reset_pin, nmi_pin, ext_req_pin, irq_masked_pin, irq_enabled_pin};
      wake_s2_r <= wake_s1_r;
    end
  end
  logic w_irq;
  logic w_masked;
  logic w_ext;
  logic w_nmi;
  logic w_rst;
  assign {w_rst, w_nmi, w_ext, w_masked, w_irq} = wake_s2_r;

  // Decode
  logic [5:0] major;
  logic [4:0] f_rt;
  logic [4:0] f_rs;
  logic [4:0] f_rd;
  ite_op_t op;
  assign major = issue_instr[31:26];
  assign f_rt = issue_instr[25:21];
  assign f_rs = issue_instr[20:16];
  assign f_rd = issue_instr[15:11];

  always_comb begin
    op = ITE_OP_NONE;
    if (major == `ITE_OP_XOR_IMM) begin
      op = ITE_OP_XOR_IMM;
    end else if (major == `ITE_OP_POOL_INT) begin
      if (issue_instr[9:0] == `ITE_FUNC_XOR && issue_instr[10] == 1'b0) begin
        op = ITE_OP_XOR;
      end else if (issue_instr[5:0] == `ITE_MINOR_INT_EXT) begin
        case (issue_instr[15:6])
          `ITE_SEC_WAIT: op = ITE_OP_WAIT;
          `ITE_SEC_WRPREV: op = release2 ? ITE_OP_WRPREV : ITE_OP_RESERVED;
          `ITE_SEC_BSWAP: op = release2 ? ITE_OP_BSWAP : ITE_OP_RESERVED;
          default: op = ITE_OP_NONE;
        endcase
      end
    end else if (major == `ITE_OP_POOL_FLT && issue_instr[5:0] == `ITE_MINOR_FLT_EXT
                 && issue_instr[15] == 1'b0) begin
      if (issue_instr[13:6] == `ITE_FSEC_TRW) begin
        op = ITE_OP_TRW;
      end else if (issue_instr[13:6] == `ITE_FSEC_TRL) begin
        op = ITE_OP_TRL;
      end
    end
  end

  ite_cvt_t cvt;
  assign cvt = trunc_fp(fs_value, issue_instr[14], op == ITE_OP_TRL);

  // Standby machine
  ite_state_t state_r;
  logic [31:0] wait_next_pc_r;
  logic go;
  logic wake;
  logic wake_hard;
  logic wake_soft;
  logic [31:0] last_pc_r;
  assign go = issue_valid && state_r == ITE_RUN;
  // Reset and non-maskable requests always end standby
  assign wake_hard = w_nmi || w_rst;
  // Masked requests wake only when software opts in
  assign wake_soft = w_irq || w_ext || (w_masked && masked_wake_en);
  assign wake = wake_hard || wake_soft;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ITE_RUN;
      wait_next_pc_r <= 32'h0;
    end else begin
      case (state_r)
        ITE_RUN: begin
          if (go && op == ITE_OP_WAIT && cp0_usable) begin
            state_r <= ITE_STANDBY;
            wait_next_pc_r <= issue_pc + 32'h4;
          end
        end
        ITE_STANDBY: begin
          if (wake) begin
            state_r <= ITE_RUN;
          end
        end
        default: state_r <= ITE_RUN;
      endcase
    end
  end

  // Drops in the wake cycle so the pipeline restarts at once
  assign standby = (state_r == ITE_STANDBY) && !wake;
  assign pipe_stall = standby;

  // Registered results and exceptions
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gpr_wr <= '0;
      shadow_wr <= '0;
      shadow_set <= 2'h0;
      fpr_wr <= '0;
      fp_cause <= '0;
      fp_invalid_flag_set <= 1'b0;
      exc_cop_unusable <= 1'b0;
      exc_reserved <= 1'b0;
      exc_fp_invalid <= 1'b0;
      exc_interrupt <= 1'b0;
      exc_nmi <= 1'b0;
      exc_reset <= 1'b0;
      exception_return_pc <= 32'h0;
      last_pc_r <= 32'h0;
    end else begin
      gpr_wr <= '0;
      shadow_wr <= '0;
      fpr_wr <= '0;
      fp_cause <= '0;
      fp_invalid_flag_set <= 1'b0;
      exc_cop_unusable <= 1'b0;
      exc_reserved <= 1'b0;
      exc_fp_invalid <= 1'b0;
      exc_interrupt <= 1'b0;
      exc_nmi <= 1'b0;
      exc_reset <= 1'b0;
      // Issue is blocked in standby, so a wake never meets a new result
      if (state_r == ITE_STANDBY && wake) begin
        exception_return_pc <= wait_next_pc_r;
        exc_reset <= w_rst;
        exc_nmi <= w_nmi && !w_rst;
        exc_interrupt <= w_irq && !w_nmi && !w_rst;
      end else if (go) begin
        last_pc_r <= issue_pc;
        case (op)
          ITE_OP_XOR_IMM: gpr_wr <= '{we: 1'b1, idx: f_rt, data: rs_value ^ {16'h0, issue_instr[15:0]}};
          ITE_OP_XOR: gpr_wr <= '{we: 1'b1, idx: f_rd, data: rs_value ^ rt_value};
          ITE_OP_BSWAP: gpr_wr <= '{we: 1'b1, idx: f_rt,
                                    data: {rs_value[23:16], rs_value[31:24], rs_value[7:0], rs_value[15:8]}};
          ITE_OP_WRPREV: begin
            shadow_wr <= '{we: 1'b1, idx: f_rt, data: rs_value};
            shadow_set <= previous_shadow_set_field;
          end
          ITE_OP_RESERVED: exc_reserved <= 1'b1;
          ITE_OP_WAIT: exc_cop_unusable <= !cp0_usable;
          ITE_OP_TRW, ITE_OP_TRL: begin
            fp_cause <= '{unimpl: cvt.unimpl, invalid: cvt.invalid, inexact: cvt.inexact};
            fp_invalid_flag_set <= cvt.invalid;
            if (cvt.invalid && fp_invalid_enable) begin
              exc_fp_invalid <= 1'b1;
              exception_return_pc <= issue_pc;
            end else if (op == ITE_OP_TRW) begin
              fpr_wr <= '{we: 1'b1, idx: f_rt, data: cvt.value};
            end else begin
              // Width mode 0 or a 32-bit unit gives no defined value
              fpr_wr <= '{we: 1'b1, idx: f_rt,
                          data: (fpu64 && fp_register_width_mode) ? cvt.value : 64'h0};
            end
          end
          default: ;
        endcase
      end
    end
  end

  assign fp_round_mode = `ITE_RMODE_TRUNC;

  // Bus read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (bus_take && !hwrite) begin
      case (haddr)
        `ITE_ADDR_OFF: hrdata <= last_pc_r;
        `ITE_ADDR_CTRL: hrdata <= ctrl_r;
        `ITE_ADDR_STAT: hrdata <= {27'h0, wake_s2_r[4:1], state_r == ITE_STANDBY};
        default: hrdata <= 32'h0;
      endcase
    end
  end

endmodule

// *** ite_pipe_model.sv ***
// Pipeline side stand-in: register files feeding the slice operands
`timescale 1ns/100ps
module ite_pipe_model (
  // Issue slot
  input wire logic issue_valid,
  input wire logic [31:0] issue_instr,
  // Operands
  output logic [31:0] rs_value,
  output logic [31:0] rt_value,
  output logic [63:0] fs_value
);
  logic [31:0] gpr [32];
  logic [63:0] fpr [32];
  initial begin
    for (int i = 0; i < 32; i++) begin
      gpr[i] = 32'h9E3779B9 * (i + 1);
      fpr[i] = 64'h0;
    end
    fpr[1] = 64'h40700000;
    fpr[2] = 64'h501502F9;
    fpr[3] = 64'hC004000000000000;
    fpr[4] = 64'h7FF0000000000000;
  end
  // Idle operands inverted so stale values never pass as live
  always_comb begin
    rs_value = gpr[issue_instr[20:16]];
    rt_value = gpr[issue_instr[25:21]];
    fs_value = fpr[issue_instr[20:16]];
    if (!issue_valid) begin
      rs_value = ~rs_value;
      rt_value = ~rt_value;
      fs_value = ~fs_value;
    end
  end
endmodule

// *** ite_slice_monitor.sv ***
// Port checker for the tail execute slice
`timescale 1ns/100ps
`include "ite_map.svh"
module ite_slice_monitor
  import ite_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Issue and wake
  input wire logic issue_valid,
  input wire logic [31:0] issue_instr,
  input wire logic [31:0] rs_value,
  input wire logic [31:0] rt_value,
  input wire logic cp0_usable,
  input wire logic release2,
  input wire logic irq_enabled_pin,
  // Results
  input wire ite_gpr_wr_t gpr_wr,
  input wire logic [1:0] fp_round_mode,
  input wire logic exc_reserved,
  input wire logic exc_cop_unusable,
  input wire logic exc_interrupt,
  input wire logic standby
);
  logic [31:0] s_r;
  logic [31:0] t_r;
  logic [31:0] i_r;
  wire logic go = issue_valid && !standby;
  wire logic pool = issue_instr[31:26] == `ITE_OP_POOL_INT && issue_instr[5:0] == `ITE_MINOR_INT_EXT;
  wire logic is_xor = go && issue_instr[31:26] == `ITE_OP_POOL_INT && issue_instr[10:0] == {1'b0, `ITE_FUNC_XOR};
  wire logic is_xri = go && issue_instr[31:26] == `ITE_OP_XOR_IMM;
  wire logic is_bsw = go && pool && issue_instr[15:6] == `ITE_SEC_BSWAP;
  wire logic is_wt = go && pool && issue_instr[15:6] == `ITE_SEC_WAIT;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk) begin
    s_r <= rs_value;
    t_r <= rt_value;
    i_r <= issue_instr;
  end
  sequence s_wake;
    ##[1:5] exc_interrupt;
  endsequence
  a_round_mode: assert property (fp_round_mode == `ITE_RMODE_TRUNC)
    else $error("round mode wrong");
  a_xor_result: assert property (is_xor |=> gpr_wr.we && gpr_wr.idx == i_r[15:11] && gpr_wr.data == (s_r ^ t_r))
    else $error("xor result wrong");
  a_xor_with_immediate_result: assert property (is_xri |=> gpr_wr.we && gpr_wr.idx == i_r[25:21] && gpr_wr.data == (s_r ^ {16'h0, i_r[15:0]}))
    else $error("xor immediate wrong");
  a_swap_bytes: assert property (is_bsw && release2 |=> gpr_wr.we && gpr_wr.data == {s_r[23:16], s_r[31:24], s_r[7:0], s_r[15:8]})
    else $error("byte swap wrong");
  a_swap_reserved: assert property (is_bsw && !release2 |=> exc_reserved && !gpr_wr.we)
    else $error("swap not reserved");
  a_wait_standby: assert property (is_wt && cp0_usable && !irq_enabled_pin |=> standby)
    else $error("no standby after wait");
  a_cop_unusable: assert property (is_wt && !cp0_usable |=> exc_cop_unusable && !standby)
    else $error("wait not refused");
  a_irq_wake: assert property ($rose(irq_enabled_pin) && standby |-> s_wake)
    else $error("interrupt wake missing");
endmodule

// *** ite_slice_tb.sv ***
// Self-checking bench for the tail execute slice
`timescale 1ns/100ps
`include "ite_map.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; $display("Error %s expected %h seen %h", n, e, g); end end
module ite_slice_tb;
  import ite_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, issue_valid = 0;
  logic [31:0] haddr = 0, hwdata = 0, issue_instr = 0, issue_pc = 0, g, rd;
  logic [1:0] htrans = 0, prev_set = 2'h2;
  logic [2:0] hsize = 3'h2;
  logic cp0 = 1, rel2 = 1, f64 = 1, wmode = 1, inv_en = 0;
  logic [4:0] wk = 0;
  wire logic [31:0] hrdata, rs_value, rt_value, ret_pc;
  wire logic [63:0] fs_value;
  wire logic [5:0] ex;
  wire logic [1:0] sset;
  wire logic hreadyout, hresp, standby, pstall, fflag;
  wire ite_gpr_wr_t gpr_wr, shadow_wr;
  wire ite_fpr_wr_t fpr_wr;
  wire ite_fcause_t fcause;
  int error_cnt = 0, comparisons = 0, n;
  always #12.5 hclk = ~hclk;
  ite_pipe_model PIPE (.issue_valid(issue_valid), .issue_instr(issue_instr), .rs_value(rs_value),
    .rt_value(rt_value), .fs_value(fs_value));
  ite_slice DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .issue_valid(issue_valid), .issue_instr(issue_instr), .issue_pc(issue_pc), .rs_value(rs_value),
    .rt_value(rt_value), .fs_value(fs_value), .cp0_usable(cp0), .release2(rel2), .fpu64(f64),
    .fp_register_width_mode(wmode), .previous_shadow_set_field(prev_set), .fp_invalid_enable(inv_en),
    .irq_enabled_pin(wk[0]), .nmi_pin(wk[1]), .soft_reset_pin(wk[2]), .ext_req_pin(wk[3]),
    .irq_masked_pin(wk[4]), .gpr_wr(gpr_wr), .shadow_wr(shadow_wr), .shadow_set(sset), .fpr_wr(fpr_wr),
    .fp_cause(fcause), .fp_invalid_flag_set(fflag), .fp_round_mode(), .exc_cop_unusable(ex[0]),
    .exc_reserved(ex[1]), .exc_fp_invalid(ex[2]), .exc_interrupt(ex[3]), .exc_nmi(ex[4]), .exc_reset(ex[5]),
    .exception_return_pc(ret_pc), .pipe_stall(pstall), .standby(standby));
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic iss(input logic [31:0] ins, input logic [31:0] pc);
    @(posedge hclk);
    issue_valid <= 1;
    issue_instr <= ins;
    issue_pc <= pc;
    @(posedge hclk);
    issue_valid <= 0;
    #1;
  endtask
  task automatic trc(input logic [7:0] sec, input logic [4:0] fs, input logic en, input logic [64:0] wd,
    input logic [4:0] iv);
    @(posedge hclk);
    inv_en <= en;
    iss({6'h15, 5'd2, fs, 1'b0, fs > 5'd2, sec, 6'h3B}, 32'h200);
    `CHK("fp result", wd, {fpr_wr.we, fpr_wr.we ? fpr_wr.data : 64'h0})
    `CHK("fp flags", iv, {fflag, ex[2], fcause})
    if (en) `CHK("trap pc", 32'h200, ret_pc)
  endtask
  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    test_done;
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1;
    bus(0, `ITE_ADDR_CTRL, 0);
    `CHK("ctrl", `ITE_CTRL_RESET, rd)
    `CHK("resp", 1'b0, hresp)
    bus(0, 32'h10, 0);
    `CHK("unmapped", 32'h0, rd)
    iss({6'h00, 5'd3, 5'd4, 5'd9, 1'b0, `ITE_FUNC_XOR}, 32'h40);
    `CHK("xor", {1'b1, 5'd9, PIPE.gpr[4] ^ PIPE.gpr[3], 6'h0}, {gpr_wr, ex})
    iss({`ITE_OP_XOR_IMM, 5'd5, 5'd6, 16'h8001}, 32'h44);
    `CHK("xor_with_immediate", {1'b1, 5'd5, PIPE.gpr[6] ^ 32'h8001}, gpr_wr)
    bus(0, `ITE_ADDR_OFF, 0);
    `CHK("last pc", 32'h44, rd)
    for (int r = 1; r >= 0; r--) begin
      @(posedge hclk);
      rel2 <= r[0];
      g = PIPE.gpr[8];
      iss({6'h00, 5'd7, 5'd8, `ITE_SEC_BSWAP, `ITE_MINOR_INT_EXT}, 32'h48);
      if (r) `CHK("swap", {1'b1, 5'd7, g[23:16], g[31:24], g[7:0], g[15:8]}, gpr_wr)
      else `CHK("swap refused", 7'h02, {gpr_wr.we, ex})
      iss({6'h00, 5'd10, 5'd11, `ITE_SEC_WRPREV, `ITE_MINOR_INT_EXT}, 32'h4C);
      if (r) `CHK("shadow", {1'b1, 5'd10, PIPE.gpr[11], 2'h2}, {shadow_wr, sset})
      else `CHK("shadow refused", 7'h02, {shadow_wr.we, ex})
    end
    $display("integer tests done");
    trc(`ITE_FSEC_TRW, 5'd1, 0, {1'b1, 64'h3}, 5'b00001);
    trc(`ITE_FSEC_TRW, 5'd2, 0, {1'b1, 64'h7FFFFFFF}, 5'b10010);
    trc(`ITE_FSEC_TRW, 5'd2, 1, {1'b0, 64'h0}, 5'b11010);
    trc(`ITE_FSEC_TRL, 5'd3, 0, {1'b1, 64'hFFFFFFFFFFFFFFFE}, 5'b00001);
    trc(`ITE_FSEC_TRL, 5'd4, 0, {1'b1, `ITE_L_MAX}, 5'b10010);
    @(posedge hclk);
    f64 <= 0;
    trc(`ITE_FSEC_TRL, 5'd3, 0, {1'b1, 64'h0}, 5'b00001);
    @(posedge hclk);
    f64 <= 1;
    $display("truncation tests done");
    @(posedge hclk);
    cp0 <= 0;
    iss({6'h00, 10'h0, `ITE_SEC_WAIT, `ITE_MINOR_INT_EXT}, 32'h80);
    `CHK("wait refused", 7'h02, {ex, standby})
    @(posedge hclk);
    cp0 <= 1;
    for (int k = 0; k < 5; k++) begin
      iss({6'h00, 10'(k), `ITE_SEC_WAIT, `ITE_MINOR_INT_EXT}, 32'h100 + 16 * k);
      `CHK("standby", 1'b1, standby)
      `CHK("stall", 1'b1, pstall)
      @(posedge hclk);
      wk[k] <= 1;
      if (k == 4) begin
        repeat (6) @(posedge hclk);
        #1;
        `CHK("masked hold", 1'b1, standby)
        bus(0, `ITE_ADDR_STAT, 0);
        `CHK("status", 32'h3, rd)
        bus(1, `ITE_ADDR_CTRL, 32'h1);
      end
      #1;
      n = 0;
      while (standby !== 1'b0 && n < 20) begin
        @(posedge hclk);
        #1;
        n++;
      end
      `CHK("wake", 1'b0, standby)
      @(posedge hclk);
      #1;
      `CHK("wake exception", (k < 3) ? 6'h08 << k : 6'h00, ex)
      if (k < 3) `CHK("return pc", 32'h104 + 16 * k, ret_pc)
      @(posedge hclk);
      wk <= 0;
      repeat (4) @(posedge hclk);
    end
    $display("standby tests done");
    test_done;
  end
endmodule
bind ite_slice ite_slice_monitor MON (.hclk(hclk), .hresetn(hresetn), .issue_valid(issue_valid),
  .issue_instr(issue_instr), .rs_value(rs_value), .rt_value(rt_value), .cp0_usable(cp0_usable),
  .release2(release2), .irq_enabled_pin(irq_enabled_pin), .gpr_wr(gpr_wr), .fp_round_mode(fp_round_mode),
  .exc_reserved(exc_reserved), .exc_cop_unusable(exc_cop_unusable), .exc_interrupt(exc_interrupt),
  .standby(standby));
